// [hw/analog_output_timing_engine.sv]
// Functional notes
// - Software-timed mode makes exactly one DAC update per software update command.
// - Hardware-timed modes pace updates from an internal or external sample clock.
// - Timed single point flags lateness when a sample clock beats fresh data.
// - Buffered mode fills the FIFO from DMA and pops one sample per clock.
// - Finite mode produces exactly the programmed sample count, then stops clocking.
// - Continuous mode runs with no count limit until a stop command.
// - Host regeneration (default) keeps fetching the host buffer into the FIFO.
// - FIFO-only regeneration loads the buffer once and cycles it; host stays within it.
// - Without regeneration old samples never repeat; an empty FIFO flags underflow.
// - Generation starts on the selected trigger, or on software start if none.
// - Retriggerable mode produces a full burst for every start trigger received while armed.
// - Triggers during a burst are ignored; the engine re-arms after the burst.
// - Digital start detects a chosen edge on terminals or bus lines; software start is a command pulse.
// - Analog start begins on the first rising edge of the comparison event.
// - Exported start trigger is an active-high pulse; terminals default to input.
// - While pause is active no sample updates happen.
// - A sample in progress completes; pause applies from the next sample.
// - With the onboard timebase, generation resumes at once when pause ends.
// - With an outside clock, generation resumes at the first edge after pause ends.
// - Digital pause has programmable polarity and is level sensitive.
// - Analog pause holds sampling while the comparison event is high.
// - Each sample clock updates all enabled channels together; edge is selectable.
// - Internal engine delays first sample clock after trigger, default two ticks.
// - Internal sample clock divides the timebase by a programmable counter.
`include "aote_cfg.svh"

module analog_output_timing_engine (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dma_valid,
  input wire logic [31:0] dma_data,
  output logic dma_ready,
  input wire logic [`AOTE_PFI_N-1:0] programmable_io_terminal_in,
  output logic [`AOTE_PFI_N-1:0] programmable_io_terminal_out,
  output logic [`AOTE_PFI_N-1:0] programmable_io_terminal_oe,
  input wire logic [7:0] trigger_bus_line,
  input wire logic analog_cmp_event,
  input wire logic ext_sample_clock,
  output logic [31:0] dac_data,
  output logic [`AOTE_CHANNELS-1:0] dac_update,
  output logic gen_sample_clock,
  output logic gen_start_trigger
);

  aote_pkg::state_s q;
  aote_pkg::state_s d;

  aote_pkg::mode_e mode;
  aote_pkg::src_e tsrc;
  aote_pkg::src_e psrc;
  logic acc;
  logic wr_acc;
  logic [31:0] wmask;
  logic [31:0] cmd;
  logic buffered;
  logic fifo_only;
  logic regen;
  logic clk_ext;
  logic [4:0] tline;
  logic [4:0] pline;
  logic trig_lvl;
  logic trig_hit;
  logic pause_lvl;
  logic paused;
  logic sclk_lvl;
  logic tick;
  logic sample_evt;
  logic fifo_empty;
  logic pop;
  logic push;
  logic last;
  logic [31:0] pop_data;
  logic [`AOTE_LINES-1:0] pins;

  assign mode = aote_pkg::mode_e'(q.ctrl[`AOTE_CTRL_MODE_HI:`AOTE_CTRL_MODE_LO]);
  assign tsrc = aote_pkg::src_e'(q.ctrl[`AOTE_CTRL_TSRC_HI:`AOTE_CTRL_TSRC_LO]);
  assign psrc = aote_pkg::src_e'(q.ctrl[`AOTE_CTRL_PSRC_HI:`AOTE_CTRL_PSRC_LO]);
  assign regen = q.ctrl[`AOTE_CTRL_REGEN];
  assign fifo_only = q.ctrl[`AOTE_CTRL_FIFO_ONLY];
  assign clk_ext = q.ctrl[`AOTE_CTRL_CLK_EXT];
  assign tline = q.ctrl[`AOTE_CTRL_TLINE_HI:`AOTE_CTRL_TLINE_LO];
  assign pline = q.ctrl[`AOTE_CTRL_PLINE_HI:`AOTE_CTRL_PLINE_LO];
  assign buffered = (mode == aote_pkg::MODE_FINITE) || (mode == aote_pkg::MODE_CONT);

  // Avalon slave: one wait cycle, then answer
  assign acc = q.ack && (avs_read || avs_write);
  assign wr_acc = acc && avs_write;
  assign avs_waitrequest = (avs_read || avs_write) && !q.ack;
  assign avs_readdata = q.rdata;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign cmd = (wr_acc && avs_address == `AOTE_OFS_CMD) ? (avs_writedata & wmask) : 32'h0;

  assign pins = {ext_sample_clock, analog_cmp_event, trigger_bus_line,
                 programmable_io_terminal_in};

  // Start trigger source and edge
  always_comb begin
    trig_lvl = q.filt[tline];
    if (tsrc == aote_pkg::SRC_ANALOG) begin
      trig_lvl = q.filt[`AOTE_LINE_ACMP];
    end
  end

  always_comb begin
    case (tsrc)
      aote_pkg::SRC_SW: trig_hit = cmd[`AOTE_CMD_TRIG];
      aote_pkg::SRC_DIGITAL: trig_hit = q.ctrl[`AOTE_CTRL_TEDGE] ?
          (q.trig_prev && !trig_lvl) : (!q.trig_prev && trig_lvl);
      aote_pkg::SRC_ANALOG: trig_hit = !q.trig_prev && trig_lvl;
      default: trig_hit = 1'b0;
    endcase
  end

  // Pause level
  always_comb begin
    case (psrc)
      aote_pkg::SRC_DIGITAL: pause_lvl = q.filt[pline] == q.ctrl[`AOTE_CTRL_PPOL];
      aote_pkg::SRC_ANALOG: pause_lvl = q.filt[`AOTE_LINE_ACMP];
      default: pause_lvl = 1'b0;
    endcase
  end
  assign paused = pause_lvl && (q.st == aote_pkg::ST_RUN);

  // Sample clock: divided timebase or selected external edge
  assign sclk_lvl = q.filt[`AOTE_LINE_SCLK];
  always_comb begin
    if (clk_ext) begin
      tick = q.ctrl[`AOTE_CTRL_CLK_EDGE] ? (q.sclk_prev && !sclk_lvl) :
             (!q.sclk_prev && sclk_lvl);
    end else begin
      tick = q.div_cnt >= q.div - 16'h0001;
    end
  end
  // Paused outside-clock edges are dropped, so resumption waits for the next edge
  assign sample_evt = (q.st == aote_pkg::ST_RUN) && tick && !paused
                      && mode != aote_pkg::MODE_SW;

  assign fifo_empty = fifo_only ? !q.loaded : (q.level == '0);
  assign pop = sample_evt && buffered && !fifo_empty;
  assign pop_data = q.mem[q.rd_ptr];
  assign dma_ready = buffered && (q.level < `AOTE_LVL_W'(`AOTE_FIFO_DEPTH))
                     && !(fifo_only && q.loaded);
  assign push = dma_valid && dma_ready;
  assign last = (mode == aote_pkg::MODE_FINITE) && (q.done_cnt == q.cnt - 24'h00_0001);

  always_comb begin
    d = q;
    d.sy1 = pins;
    d.sy2 = q.sy1;
    d.sy3 = q.sy2;
    for (int i = 0; i < `AOTE_LINES; i++) begin
      if (q.sy2[i] == q.sy3[i]) begin
        d.filt[i] = q.sy3[i];
      end
    end
    d.trig_prev = trig_lvl;
    d.sclk_prev = sclk_lvl;
    d.dac_upd = '0;
    d.sclk_out = 1'b0;
    d.trig_pulse = 1'b0;

    // Bus
    d.ack = (avs_read || avs_write) && !q.ack;
    if (avs_read && !q.ack) begin
      case (avs_address)
        `AOTE_OFS_CTRL: d.rdata = q.ctrl;
        `AOTE_OFS_DIV: d.rdata = {16'h0, q.div};
        `AOTE_OFS_DLY: d.rdata = {16'h0, q.dly};
        `AOTE_OFS_CNT: d.rdata = {8'h0, q.cnt};
        `AOTE_OFS_STAT: d.rdata = {1'b0, q.done_cnt[15:0], q.level,
                                   q.loaded, q.underflow, q.late, q.fresh, q.st};
        `AOTE_OFS_BUFLEN: d.rdata = {25'h0, q.buflen};
        `AOTE_OFS_CHEN: d.rdata = {28'h0, q.chen};
        default: d.rdata = 32'h0;
      endcase
    end
    if (wr_acc) begin
      case (avs_address)
        `AOTE_OFS_CTRL: d.ctrl = (q.ctrl & ~wmask) | (avs_writedata & wmask);
        `AOTE_OFS_DIV: d.div = (q.div & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
        `AOTE_OFS_DLY: d.dly = (q.dly & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
        `AOTE_OFS_CNT: d.cnt = (q.cnt & ~wmask[23:0]) | (avs_writedata[23:0] & wmask[23:0]);
        `AOTE_OFS_SAMPLE: begin
          d.hold = (q.hold & ~wmask) | (avs_writedata & wmask);
          d.fresh = 1'b1;
        end
        `AOTE_OFS_BUFLEN: begin
          if (avs_byteenable[0]) begin
            d.buflen = avs_writedata[`AOTE_LVL_W-1:0];
          end
        end
        `AOTE_OFS_CHEN: begin
          if (avs_byteenable[0]) begin
            d.chen = avs_writedata[`AOTE_CHANNELS-1:0];
          end
        end
        default: d.ctrl = q.ctrl;
      endcase
    end
    if (cmd[`AOTE_CMD_CLEAR]) begin
      d.late = 1'b0;
      d.underflow = 1'b0;
    end

    // Software-timed update
    if (mode == aote_pkg::MODE_SW && cmd[`AOTE_CMD_UPDATE]) begin
      d.dac_data = d.hold;
      d.dac_upd = q.chen;
      d.fresh = 1'b0;
    end

    // Timebase divider, held while paused
    if (q.st == aote_pkg::ST_RUN && !clk_ext && !paused) begin
      d.div_cnt = tick ? 16'h0 : q.div_cnt + 16'h0001;
    end

    case (q.st)
      aote_pkg::ST_IDLE: begin
        if (cmd[`AOTE_CMD_START] && mode != aote_pkg::MODE_SW) begin
          d.st = aote_pkg::ST_ARMED;
        end
      end
      aote_pkg::ST_ARMED: begin
        if (tsrc == aote_pkg::SRC_NONE || trig_hit) begin
          d.st = clk_ext ? aote_pkg::ST_RUN : aote_pkg::ST_DELAY;
          d.dly_cnt = 16'h0;
          d.div_cnt = 16'h0;
          d.done_cnt = 24'h0;
          d.trig_pulse = 1'b1;
        end
      end
      aote_pkg::ST_DELAY: begin
        d.dly_cnt = q.dly_cnt + 16'h0001;
        if (q.dly_cnt + 16'h0001 >= q.dly) begin
          d.st = aote_pkg::ST_RUN;
          d.div_cnt = q.div - 16'h0001;
        end
      end
      aote_pkg::ST_RUN: begin
        // Start triggers are not looked at here
        if (sample_evt) begin
          d.sclk_out = 1'b1;
          d.done_cnt = q.done_cnt + 24'h00_0001;
          if (mode == aote_pkg::MODE_SINGLE) begin
            if (q.fresh) begin
              d.dac_data = q.hold;
              d.dac_upd = q.chen;
              d.fresh = wr_acc && avs_address == `AOTE_OFS_SAMPLE;
            end else begin
              d.late = 1'b1;
            end
          end else if (pop) begin
            d.dac_data = pop_data;
            d.dac_upd = q.chen;
          end else if (!regen && !fifo_only) begin
            d.underflow = 1'b1;
          end
          if (last) begin
            d.st = q.ctrl[`AOTE_CTRL_RETRIG] ? aote_pkg::ST_ARMED :
                   aote_pkg::ST_IDLE;
          end
        end
      end
      default: d.st = aote_pkg::ST_IDLE;
    endcase
    if (cmd[`AOTE_CMD_STOP]) begin
      d.st = aote_pkg::ST_IDLE;
      d.sclk_out = 1'b0;
      d.dac_upd = (mode == aote_pkg::MODE_SW) ? d.dac_upd : '0;
    end

    // FIFO; in FIFO-only mode the stored buffer is read circularly
    if (pop && !cmd[`AOTE_CMD_STOP]) begin
      if (fifo_only) begin
        d.rd_ptr = (`AOTE_LVL_W'(q.rd_ptr) + 1'b1 >= q.buflen) ? '0 :
                   q.rd_ptr + 1'b1;
      end else begin
        d.rd_ptr = q.rd_ptr + 1'b1;
        d.level = q.level - 1'b1;
      end
    end
    if (push) begin
      d.mem[q.wr_ptr] = dma_data;
      d.wr_ptr = q.wr_ptr + 1'b1;
      d.level = d.level + 1'b1;
      if (fifo_only && q.level + 1'b1 >= q.buflen) begin
        d.loaded = 1'b1;
      end
    end
    if (cmd[`AOTE_CMD_FLUSH]) begin
      d.wr_ptr = '0;
      d.rd_ptr = '0;
      d.level = '0;
      d.loaded = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= aote_pkg::ST_IDLE;
      q.ctrl <= `AOTE_CTRL_RST;
      q.div <= `AOTE_DIV_RST;
      q.dly <= `AOTE_DLY_RST;
      q.cnt <= `AOTE_CNT_RST;
      q.buflen <= `AOTE_BUFLEN_RST;
      q.chen <= `AOTE_CHEN_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign dac_data = q.dac_data;
  assign gen_sample_clock = q.sclk_out;
  assign gen_start_trigger = q.trig_pulse;

  genvar g;
  generate
    for (g = 0; g < `AOTE_CHANNELS; g++) begin : g_chan
      assign dac_update[g] = q.dac_upd[g];
    end
    for (g = 0; g < `AOTE_PFI_N; g++) begin : g_pfi
      assign programmable_io_terminal_oe[g] = q.ctrl[`AOTE_CTRL_TEXPORT]
                                              && tline == 5'(g);
      assign programmable_io_terminal_out[g] = q.trig_pulse;
    end
  endgenerate

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_stop_cmd;
    clk_en && cmd[`AOTE_CMD_STOP] && mode != aote_pkg::MODE_SW;
  endsequence
  sequence s_idle_quiet;
    q.st == aote_pkg::ST_IDLE && dac_update == '0 && !gen_sample_clock;
  endsequence

  a_sw_single_update: assert property (
    clk_en && mode == aote_pkg::MODE_SW && cmd[`AOTE_CMD_UPDATE] |=>
      dac_update == $past(q.chen) && dac_data == $past(d.hold))
    else $error("software update did not reach dacs");
  a_late_flag_set: assert property (
    clk_en && sample_evt && mode == aote_pkg::MODE_SINGLE && !q.fresh |=>
      q.late && dac_update == '0)
    else $error("late sample not flagged");
  a_finite_count_end: assert property (
    clk_en && sample_evt && last && !q.ctrl[`AOTE_CTRL_RETRIG] && !cmd[`AOTE_CMD_STOP] |=>
      q.st == aote_pkg::ST_IDLE && q.done_cnt == $past(q.cnt))
    else $error("finite run did not end on count");
  a_pause_no_update: assert property (
    clk_en && paused && mode != aote_pkg::MODE_SW |=> dac_update == '0 && !gen_sample_clock)
    else $error("update during pause");
  a_burst_ignores_trig: assert property (
    clk_en && q.st == aote_pkg::ST_RUN && trig_hit && !sample_evt && !cmd[`AOTE_CMD_STOP] |=>
      q.st == aote_pkg::ST_RUN && !gen_start_trigger)
    else $error("trigger accepted during burst");
  a_delay_to_run: assert property (
    clk_en && q.st == aote_pkg::ST_ARMED && !clk_ext && !cmd[`AOTE_CMD_STOP] &&
      (tsrc == aote_pkg::SRC_NONE || trig_hit) && q.dly == 16'h0002 ##1
      clk_en && !cmd[`AOTE_CMD_STOP] ##1 clk_en && !cmd[`AOTE_CMD_STOP] |=>
      q.st == aote_pkg::ST_RUN)
    else $error("start delay not honoured");
  a_stop_goes_idle: assert property (
    s_stop_cmd |=> s_idle_quiet)
    else $error("stop did not idle the engine");
  a_trig_pulse_once: assert property (
    gen_start_trigger |-> $past(q.st) == aote_pkg::ST_ARMED ##1 !gen_start_trigger)
    else $error("start trigger pulse too long");
  a_underflow_flag: assert property (
    clk_en && sample_evt && buffered && !pop && !regen && !fifo_only |=>
      q.underflow && dac_update == '0)
    else $error("underflow not flagged");

endmodule // analog_output_timing_engine

// [hw/aote_cfg.svh]
`ifndef AOTE_CFG_SVH
`define AOTE_CFG_SVH

// Register byte offsets
`define AOTE_OFS_CTRL    6'h00
`define AOTE_OFS_CMD     6'h04
`define AOTE_OFS_DIV     6'h08
`define AOTE_OFS_DLY     6'h0c
`define AOTE_OFS_CNT     6'h10
`define AOTE_OFS_STAT    6'h14
`define AOTE_OFS_SAMPLE  6'h18
`define AOTE_OFS_BUFLEN  6'h1c
`define AOTE_OFS_CHEN    6'h20

// Control fields
`define AOTE_CTRL_MODE_LO   0
`define AOTE_CTRL_MODE_HI   1
`define AOTE_CTRL_REGEN     2
`define AOTE_CTRL_FIFO_ONLY 3
`define AOTE_CTRL_TSRC_LO   4
`define AOTE_CTRL_TSRC_HI   5
`define AOTE_CTRL_TEDGE     6
`define AOTE_CTRL_RETRIG    7
`define AOTE_CTRL_PSRC_LO   8
`define AOTE_CTRL_PSRC_HI   9
`define AOTE_CTRL_PPOL      10
`define AOTE_CTRL_CLK_EXT   11
`define AOTE_CTRL_CLK_EDGE  12
`define AOTE_CTRL_TEXPORT   13
`define AOTE_CTRL_TLINE_LO  14
`define AOTE_CTRL_TLINE_HI  18
`define AOTE_CTRL_PLINE_LO  19
`define AOTE_CTRL_PLINE_HI  23
`define AOTE_CTRL_RST       32'h0000_0004

// Command bits
`define AOTE_CMD_START  0
`define AOTE_CMD_STOP   1
`define AOTE_CMD_UPDATE 2
`define AOTE_CMD_TRIG   3
`define AOTE_CMD_CLEAR  4
`define AOTE_CMD_FLUSH  5

// Reset values
`define AOTE_DIV_RST    16'h0004
`define AOTE_DLY_RST    16'h0002
`define AOTE_CNT_RST    24'h00_0004
`define AOTE_BUFLEN_RST 7'h40
`define AOTE_CHEN_RST   4'hf

// Sizes
`define AOTE_CHANNELS   4
`define AOTE_FIFO_DEPTH 64
`define AOTE_PTR_W      6
`define AOTE_LVL_W      7
`define AOTE_LINES      26
`define AOTE_LINE_ACMP  24
`define AOTE_LINE_SCLK  25
`define AOTE_PFI_N      16

`endif

// [hw/aote_pkg.sv]
`include "aote_cfg.svh"

package aote_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_DELAY = 4'b0100,
    ST_RUN   = 4'b1000
  } state_e;

  typedef enum logic [1:0] {
    MODE_SW       = 2'h0,
    MODE_SINGLE   = 2'h1,
    MODE_FINITE   = 2'h2,
    MODE_CONT     = 2'h3
  } mode_e;

  typedef enum logic [1:0] {
    SRC_NONE    = 2'h0,
    SRC_SW      = 2'h1,
    SRC_DIGITAL = 2'h2,
    SRC_ANALOG  = 2'h3
  } src_e;

  typedef logic [31:0] word_t;

  typedef struct packed {
    state_e st;
    logic [`AOTE_LINES-1:0] sy1;
    logic [`AOTE_LINES-1:0] sy2;
    logic [`AOTE_LINES-1:0] sy3;
    logic [`AOTE_LINES-1:0] filt;
    logic trig_prev;
    logic sclk_prev;
    word_t ctrl;
    logic [`AOTE_CHANNELS-1:0] chen;
    logic [15:0] div;
    logic [15:0] dly;
    logic [23:0] cnt;
    logic [`AOTE_LVL_W-1:0] buflen;
    logic [15:0] div_cnt;
    logic [15:0] dly_cnt;
    logic [23:0] done_cnt;
    word_t hold;
    logic fresh;
    logic late;
    logic underflow;
    word_t dac_data;
    logic [`AOTE_CHANNELS-1:0] dac_upd;
    logic sclk_out;
    logic trig_pulse;
    logic [`AOTE_FIFO_DEPTH-1:0][31:0] mem;
    logic [`AOTE_PTR_W-1:0] wr_ptr;
    logic [`AOTE_PTR_W-1:0] rd_ptr;
    logic [`AOTE_LVL_W-1:0] level;
    logic loaded;
    logic ack;
    word_t rdata;
  } state_s;

endpackage

// [testbench/dma_feed_model.sv]
module dma_feed_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic stall,
  input wire logic [7:0] words,
  input wire logic [31:0] base,
  input wire logic dma_ready,
  output logic dma_valid,
  output logic [31:0] dma_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q;
  logic [31:0] nxt_q;
  logic [31:0] last_q;
  logic hold_q;
  // Host sends only the words it was given, then goes quiet
  assign dma_valid = (left_q != 8'h00) && !hold_q;
  // Released bus shows the inverse of the last word
  assign dma_data = dma_valid ? nxt_q : ~last_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 8'h00;
      nxt_q <= 32'h0;
      last_q <= 32'h0;
      hold_q <= 1'b0;
    end else begin
      if (go) begin
        left_q <= words;
        nxt_q <= base;
      end else if (dma_valid && dma_ready) begin
        left_q <= left_q - 8'h01;
        nxt_q <= nxt_q + 32'h1;
        last_q <= nxt_q;
      end
      // Stall only between words, never while one is offered
      if (!(dma_valid && !dma_ready)) begin
        hold_q <= stall;
      end
    end
  end
endmodule // dma_feed_model

// [testbench/analog_output_timing_engine_test.sv]
`include "aote_cfg.svh"

`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("wrong value at %0t: %h vs %h", $time, g, e); \
    end \
  end

module analog_output_timing_engine_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, dma_data, dac_data, rd, v, mv, b;
  logic avs_waitrequest, dma_valid, dma_ready, sclk, strig;
  logic [15:0] pin_in = 16'h0000;
  logic [15:0] pin_out, pin_oe;
  logic acmp = 1'b0;
  logic xclk = 1'b0;
  logic go = 1'b0;
  logic stall = 1'b0;
  logic [7:0] words = 8'h00;
  logic [31:0] base = 32'h0;
  logic [3:0] dac_update;
  logic [3:0] chen_exp = 4'hf;
  logic [31:0] exp_q[$];
  int seed = 32'h4399;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int ns = 0;
  int nt = 0;
  int s, t0;
  logic [5:0] ra[8] = '{6'h00, 6'h08, 6'h0c, 6'h10, 6'h1c, 6'h20, 6'h14, 6'h3c};
  logic [31:0] rv[8] = '{32'h4, 32'h4, 32'h2, 32'h4, 32'h40, 32'hf, 32'h1, 32'h0};

  always #12.5 ref_clk = ~ref_clk;

  analog_output_timing_engine i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
    .programmable_io_terminal_in(pin_in), .programmable_io_terminal_out(pin_out),
    .programmable_io_terminal_oe(pin_oe), .trigger_bus_line(8'h00),
    .analog_cmp_event(acmp), .ext_sample_clock(xclk), .dac_data(dac_data),
    .dac_update(dac_update), .gen_sample_clock(sclk), .gen_start_trigger(strig)
  );

  dma_feed_model i_feed (
    .ref_clk(ref_clk), .rst_n(rst_n), .go(go), .stall(stall), .words(words),
    .base(base), .dma_ready(dma_ready), .dma_valid(dma_valid), .dma_data(dma_data)
  );

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    do bus(1'b0, `AOTE_OFS_STAT, 32'h0); while ((rd & m) !== e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One slow period on the outside sample clock pin
  task automatic xpulse();
    xclk <= 1'b1;
    idle(8);
    xclk <= 1'b0;
    idle(8);
  endtask

  // Flush, push n words from the host, expect the first k
  task automatic load(input logic [7:0] n, input int k);
    b = $random(seed);
    bus(1'b1, `AOTE_OFS_CMD, 32'h20);
    words <= n;
    base <= b;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    poll(32'h7f00, {17'h0, n[6:0], 8'h00});
    for (int i = 0; i < k; i++) exp_q.push_back(b + i);
  endtask

  task automatic run_stop();
    bus(1'b1, `AOTE_OFS_CMD, 32'h2);
    poll(32'hf, 32'h1);
  endtask

  always @(posedge ref_clk) begin
    if (sclk === 1'b1) ns++;
    if (strig === 1'b1) nt++;
    stall <= ($random(seed) % 3) == 0;
    if (rst_n && dac_update !== 4'h0) begin
      if (exp_q.size() == 0) `CHK(dac_update, 4'h0)
      else begin
        mv = exp_q.pop_front();
        `CHK(dac_data, mv)
        `CHK(dac_update, chen_exp)
      end
    end
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    `CHK(pin_oe, 16'h0000)
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ra[i], 32'h0);
      `CHK(rd, rv[i])
    end
    $display("test reset values done");
    chen_exp = 4'h1 | 4'($random(seed));
    bus(1'b1, `AOTE_OFS_CHEN, {28'h0, chen_exp});
    bus(1'b1, `AOTE_OFS_CTRL, 32'h0);
    repeat (2) begin
      v = $random(seed);
      exp_q.push_back(v);
      bus(1'b1, `AOTE_OFS_SAMPLE, v);
      bus(1'b1, `AOTE_OFS_CMD, 32'h4);
    end
    idle(10);
    `CHK(exp_q.size(), 0)
    $display("test software timed done");
    bus(1'b1, `AOTE_OFS_CTRL, 32'h2);
    load(8'd6, 4);
    s = ns;
    bus(1'b1, `AOTE_OFS_CMD, 32'h1);
    poll(32'hf, 32'h1);
    `CHK(ns - s, 4)
    `CHK(exp_q.size(), 0)
    $display("test finite done");
    bus(1'b1, `AOTE_OFS_CTRL, 32'ha);
    bus(1'b1, `AOTE_OFS_BUFLEN, 32'h3);
    load(8'd3, 0);
    for (int i = 0; i < 4; i++) exp_q.push_back(b + i % 3);
    poll(32'h80, 32'h80);
    bus(1'b1, `AOTE_OFS_CMD, 32'h1);
    poll(32'hf, 32'h1);
    `CHK(exp_q.size(), 0)
    $display("test fifo regeneration done");
    bus(1'b1, `AOTE_OFS_CTRL, 32'he092);
    load(8'd8, 8);
    s = ns;
    t0 = nt;
    bus(1'b1, `AOTE_OFS_CMD, 32'h1);
    poll(32'hf, 32'h2);
    `CHK(pin_oe, 16'h0008)
    bus(1'b1, `AOTE_OFS_CMD, 32'h8);
    idle(1);
    bus(1'b1, `AOTE_OFS_CMD, 32'h8);
    idle(6);
    poll(32'hf, 32'h2);
    bus(1'b1, `AOTE_OFS_CMD, 32'h8);
    idle(6);
    poll(32'hf, 32'h2);
    `CHK(ns - s, 8)
    `CHK(nt - t0, 2)
    run_stop();
    $display("test retrigger done");
    bus(1'b1, `AOTE_OFS_CTRL, 32'h14062);
    load(8'd0, 0);
    bus(1'b1, `AOTE_OFS_CMD, 32'h1);
    pin_in[5] <= 1'b1;
    idle(10);
    bus(1'b0, `AOTE_OFS_STAT, 32'h0);
    `CHK(rd[3:0], 4'h2)
    pin_in[5] <= 1'b0;
    idle(10);
    bus(1'b0, `AOTE_OFS_STAT, 32'h0);
    `CHK(rd[3:0] !== 4'h2, 1'b1)
    run_stop();
    $display("test digital edge done");
    acmp <= 1'b1;
    bus(1'b1, `AOTE_OFS_CTRL, 32'h32);
    bus(1'b1, `AOTE_OFS_CMD, 32'h1);
    idle(10);
    bus(1'b0, `AOTE_OFS_STAT, 32'h0);
    `CHK(rd[3:0], 4'h2)
    acmp <= 1'b0;
    idle(6);
    acmp <= 1'b1;
    idle(10);
    bus(1'b0, `AOTE_OFS_STAT, 32'h0);
    `CHK(rd[3:0] !== 4'h2, 1'b1)
    run_stop();
    $display("test analog start done");
    bus(1'b1, `AOTE_OFS_CTRL, 32'h380603);
    bus(1'b1, `AOTE_OFS_CMD, 32'h10);
    pin_in[7] <= 1'b1;
    idle(4);
    bus(1'b1, `AOTE_OFS_CMD, 32'h1);
    idle(20);
    s = ns;
    idle(20);
    `CHK(ns - s, 0)
    bus(1'b0, `AOTE_OFS_STAT, 32'h0);
    `CHK(rd[6], 1'b0)
    pin_in[7] <= 1'b0;
    idle(20);
    `CHK(ns - s > 0, 1'b1)
    bus(1'b0, `AOTE_OFS_STAT, 32'h0);
    `CHK(rd[6], 1'b1)
    run_stop();
    s = ns;
    idle(10);
    `CHK(ns - s, 0)
    $display("test pause and underflow done");
    bus(1'b1, `AOTE_OFS_CTRL, 32'h1);
    bus(1'b1, `AOTE_OFS_CMD, 32'h10);
    bus(1'b1, `AOTE_OFS_CMD, 32'h1);
    idle(20);
    bus(1'b0, `AOTE_OFS_STAT, 32'h0);
    `CHK(rd[5], 1'b1)
    v = $random(seed);
    exp_q.push_back(v);
    bus(1'b1, `AOTE_OFS_SAMPLE, v);
    idle(10);
    `CHK(exp_q.size(), 0)
    run_stop();
    $display("test single point done");
    bus(1'b1, `AOTE_OFS_CTRL, 32'h380e02);
    load(8'd4, 4);
    pin_in[7] <= 1'b1;
    idle(6);
    bus(1'b1, `AOTE_OFS_CMD, 32'h1);
    s = ns;
    repeat (2) xpulse();
    pin_in[7] <= 1'b0;
    idle(10);
    `CHK(ns - s, 0)
    xpulse();
    `CHK(ns - s, 1)
    repeat (3) xpulse();
    poll(32'hf, 32'h1);
    `CHK(ns - s, 4)
    `CHK(exp_q.size(), 0)
    $display("test outside clock done");
    results();
  end
endmodule // analog_output_timing_engine_test
